// ### include/fpb_params.svh
`ifndef FPB_PARAMS_SVH
`define FPB_PARAMS_SVH

// ============================================================
// Register offsets (byte addresses).
`define FPB_CTRL_OFS    8'h00
`define FPB_REMAP_OFS   8'h04
`define FPB_STAT_OFS    8'h08
`define FPB_COMP0_OFS   8'h10

// ============================================================
// Field positions.
`define FPB_CTRL_EN_BIT   0
`define FPB_COMP_EN_BIT   0
`define FPB_COMP_BKPT_BIT 1

// ============================================================
// Reset values.
`define FPB_CTRL_RST    32'h0000_0000
`define FPB_REMAP_RST   32'h2000_0000
`define FPB_COMP_RST    32'h0000_0000

// ============================================================
// Mapping constants.
`define FPB_FLASH_BASE  32'h0000_0000
`define FPB_FLASH_MASK  32'hE000_0000
// Breakpoint word returned on a breakpoint hit; the value is arbitrary.
`define FPB_BKPT_INSN   32'h0F0F_F0F0
`define FPB_SLOT_BYTES  4

`endif

// ### include/fpb_pkg.sv
package fpb_pkg;

    typedef struct packed {
        logic        valid;
        logic        is_lit;
        logic [31:0] addr;
        logic [1:0]  size;
    } fpb_req_t;

    typedef struct packed {
        logic        hit;
        logic        bkpt;
        logic [31:0] addr;
        logic        valid;
    } fpb_resp_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } fpb_wb_req_t;

endpackage

// ### rtl/fpb_comp_bank.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Comparator table with registered read port.
module fpb_comp_bank #(
    parameter int N = 8
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 wr_en,
    input  wire logic [$clog2(N)-1:0] wr_idx,
    input  wire logic [31:0]          wr_data,
    input  wire logic [$clog2(N)-1:0] rd_idx,
    output var  logic [31:0]          rd_data,
    output var  logic [N*32-1:0]      all_q
);

    typedef struct packed {
        logic [N-1:0][31:0] ent;
        logic [31:0]        rd;
    } fpb_bank_t;

    fpb_bank_t s_q;
    fpb_bank_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.ent[wr_idx] = wr_data;
        end
        s_d.rd = s_q.ent[rd_idx];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
    assign all_q   = s_q.ent;

endmodule

`default_nettype wire

// ### rtl/fpb_unit.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpb_params.svh"

// Behaviour
// - Two literal comparators match flash literal loads and redirect them to RAM.
// - Six instruction comparators match flash fetches and redirect them to RAM.
// - Each instruction comparator may instead return a breakpoint instruction.
// - A comparator acts only when its enable and the global enable are set.
// - Remapped address is remap base plus an offset chosen by the matching comparator.
// - Original flash access still runs; the remapped result replaces it.
// - Protection checks use the original address, never the remapped one.
// - Unaligned literal loads are never remapped; the original access completes.
module fpb_unit #(
    parameter int N_INSN = 6,
    parameter int N_LIT  = 2
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire fpb_pkg::fpb_wb_req_t wb_req,
    output var  logic [31:0]        wb_dat_o,
    output var  logic               wb_ack_o,
    input  wire fpb_pkg::fpb_req_t  core_req,
    output var  fpb_pkg::fpb_resp_t core_resp,
    output var  logic [31:0]        prot_addr,
    input  wire logic               flash_valid,
    input  wire logic [31:0]        flash_rdata,
    input  wire logic               ram_valid,
    input  wire logic [31:0]        ram_rdata,
    output var  logic               core_rvalid,
    output var  logic [31:0]        core_rdata
);

    localparam int N  = N_INSN + N_LIT;
    localparam int IW = $clog2(N);

    typedef enum logic [1:0] {
        FPB_IDLE = 2'b00,
        FPB_WAIT = 2'b01,
        FPB_ACK  = 2'b11
    } fpb_bus_t;

    typedef struct packed {
        fpb_bus_t           st;
        logic               en;
        logic [31:0]        remap;
        fpb_pkg::fpb_resp_t resp;
        logic [31:0]        prot;
        logic [31:0]        rdata;
        logic               rvalid;
        logic [31:0]        bus_rd;
        logic [7:0]         hits;
        logic               sel_bkpt;
        logic               sel_hit;
    } fpb_state_t;

    fpb_state_t s_q;
    fpb_state_t s_d;

    logic [31:0]   bank_rd;
    logic [N*32-1:0] comps;
    logic          bank_we;
    logic [IW-1:0] bank_idx;

    // ============================================================
    // Word-aligned comparison of one entry against an access.
    function automatic logic comp_hit(input logic [31:0] ent, input logic [31:0] a);
        comp_hit = ent[`FPB_COMP_EN_BIT] && (ent[31:2] == a[31:2]);
    endfunction

    function automatic logic is_flash(input logic [31:0] a);
        is_flash = (a & `FPB_FLASH_MASK) == `FPB_FLASH_BASE;
    endfunction

    function automatic logic aligned(input logic [31:0] a, input logic [1:0] sz);
        case (sz)
            2'd0: aligned = 1'b1;
            2'd1: aligned = ~a[0];
            default: aligned = (a[1:0] == 2'b00);
        endcase
    endfunction

    assign bank_idx = IW'((wb_req.adr[7:0] - `FPB_COMP0_OFS) >> 2);
    assign bank_we  = (s_q.st == FPB_IDLE) && wb_req.cyc && wb_req.stb && wb_req.we
                      && (wb_req.adr[7:0] >= `FPB_COMP0_OFS)
                      && (wb_req.adr[7:0] < 8'(`FPB_COMP0_OFS + 4 * N));

    fpb_comp_bank #(
        .N(N)
    ) u_bank (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (bank_we),
        .wr_idx  (bank_idx),
        .wr_data (wb_req.dat),
        .rd_idx  (bank_idx),
        .rd_data (bank_rd),
        .all_q   (comps)
    );

    // ============================================================
    // Next-state logic.
    always_comb begin
        logic          hit;
        logic [IW-1:0] idx;
        logic [7:0]    ofs;
        hit = 1'b0;
        idx = '0;
        ofs = wb_req.adr[7:0];
        s_d = s_q;

        case (s_q.st)
            FPB_IDLE: begin
                if (wb_req.cyc && wb_req.stb) begin
                    s_d.st = FPB_WAIT;
                    if (wb_req.we) begin
                        if (ofs == `FPB_CTRL_OFS && wb_req.sel[0]) begin
                            s_d.en = wb_req.dat[`FPB_CTRL_EN_BIT];
                        end else if (ofs == `FPB_REMAP_OFS) begin
                            s_d.remap = {wb_req.dat[31:5], 5'b0_0000};
                        end
                    end
                end
            end
            FPB_WAIT: begin
                s_d.st = FPB_ACK;
                if (ofs == `FPB_CTRL_OFS) begin
                    s_d.bus_rd = {31'h0000_0000, s_q.en};
                end else if (ofs == `FPB_REMAP_OFS) begin
                    s_d.bus_rd = s_q.remap;
                end else if (ofs == `FPB_STAT_OFS) begin
                    s_d.bus_rd = {24'h00_0000, s_q.hits};
                end else if (ofs >= `FPB_COMP0_OFS && ofs < 8'(`FPB_COMP0_OFS + 4 * N)) begin
                    s_d.bus_rd = bank_rd;
                end else begin
                    s_d.bus_rd = 32'h0000_0000;
                end
            end
            default: begin
                s_d.st = FPB_IDLE;
            end
        endcase

        // Instruction slots come first, literal slots after them.
        if (s_q.en && core_req.valid && is_flash(core_req.addr)) begin
            for (int i = 0; i < N; i++) begin
                if (!hit && comp_hit(comps[i*32 +: 32], core_req.addr)
                    && ((i < N_INSN) != core_req.is_lit)) begin
                    hit = 1'b1;
                    idx = IW'(i);
                end
            end
            if (core_req.is_lit && !aligned(core_req.addr, core_req.size)) begin
                hit = 1'b0;
            end
        end

        if (core_req.valid) begin
            s_d.prot = core_req.addr;
            s_d.resp.valid = 1'b1;
            s_d.resp.hit = hit;
            s_d.resp.bkpt = hit && !core_req.is_lit
                            && comps[32*idx + `FPB_COMP_BKPT_BIT];
            if (hit) begin
                s_d.resp.addr = s_q.remap
                                + 32'(idx) * `FPB_SLOT_BYTES
                                + {30'h0000_0000, core_req.addr[1:0]};
                s_d.hits = s_q.hits | (8'h01 << idx);
            end else begin
                s_d.resp.addr = core_req.addr;
            end
        end else begin
            s_d.resp.valid = 1'b0;
        end

        // Flash data of a remapped access is dropped in favour of the remap result.
        // The source choice lags the response by one cycle, in step with the memories.
        s_d.sel_bkpt = s_q.resp.valid && s_q.resp.bkpt;
        s_d.sel_hit  = s_q.resp.valid && s_q.resp.hit;
        s_d.rvalid = 1'b0;
        if (s_q.sel_bkpt) begin
            s_d.rvalid = flash_valid;
            s_d.rdata = `FPB_BKPT_INSN;
        end else if (s_q.sel_hit) begin
            s_d.rvalid = ram_valid;
            s_d.rdata = ram_rdata;
        end else begin
            s_d.rvalid = flash_valid;
            s_d.rdata = flash_rdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q.st    <= FPB_IDLE;
            s_q.en    <= 1'(`FPB_CTRL_RST >> `FPB_CTRL_EN_BIT);
            s_q.remap <= `FPB_REMAP_RST;
            s_q.resp  <= '0;
            s_q.prot  <= '0;
            s_q.rdata <= '0;
            s_q.rvalid <= 1'b0;
            s_q.bus_rd <= '0;
            s_q.hits  <= '0;
            s_q.sel_bkpt <= 1'b0;
            s_q.sel_hit  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign core_resp   = s_q.resp;
    assign prot_addr   = s_q.prot;
    assign core_rvalid = s_q.rvalid;
    assign core_rdata  = s_q.rdata;
    assign wb_dat_o    = s_q.bus_rd;
    assign wb_ack_o    = (s_q.st == FPB_ACK);

endmodule

`default_nettype wire

// ### sim/fpb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Flash always answers the original address; RAM answers remap hits.
module fpb_mem_model (
    input  wire logic               clk,
    input  wire fpb_pkg::fpb_resp_t core_resp,
    input  wire logic [31:0]        prot_addr,
    output var  logic               flash_valid,
    output var  logic [31:0]        flash_rdata,
    output var  logic               ram_valid,
    output var  logic [31:0]        ram_rdata
);
    initial {flash_valid, ram_valid, flash_rdata, ram_rdata} = '0;
    always @(posedge clk) begin
        flash_valid <= core_resp.valid;
        ram_valid   <= core_resp.valid && core_resp.hit && !core_resp.bkpt;
        flash_rdata <= core_resp.valid ? ~prot_addr : ~flash_rdata;
        ram_rdata   <= core_resp.valid ? core_resp.addr ^ 32'h5A5A_5A5A : ~ram_rdata;
    end
endmodule
`default_nettype wire

// ### sim/fpb_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpb_params.svh"
// ====
// Checker.
module fpb_unit_chk (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire fpb_pkg::fpb_wb_req_t wb_req,
    input wire logic               wb_ack_o,
    input wire fpb_pkg::fpb_req_t  core_req,
    input wire fpb_pkg::fpb_resp_t core_resp,
    input wire logic [31:0]        prot_addr,
    input wire logic               flash_valid,
    input wire logic [31:0]        flash_rdata,
    input wire logic               ram_valid,
    input wire logic [31:0]        ram_rdata,
    input wire logic               core_rvalid,
    input wire logic [31:0]        core_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_bkpt;
        core_resp.valid && core_resp.bkpt ##1 flash_valid;
    endsequence
    sequence s_hit;
        core_resp.valid && core_resp.hit && !core_resp.bkpt ##1 ram_valid;
    endsequence
    sequence s_miss;
        core_resp.valid && !core_resp.hit && !core_resp.bkpt ##1 flash_valid;
    endsequence
    a_prot_original: assert property (
        core_req.valid |=> prot_addr == $past(core_req.addr)) else $error("bad prot addr");
    a_miss_addr: assert property (
        core_resp.valid && !core_resp.hit |-> core_resp.addr == prot_addr) else $error("miss moved");
    a_hit_offset: assert property (
        core_resp.valid && core_resp.hit && !core_resp.bkpt
        |-> core_resp.addr[1:0] == prot_addr[1:0]) else $error("bad byte offset");
    a_lit_unaligned: assert property (
        core_req.valid && core_req.is_lit && ((core_req.size == 2'd1 && core_req.addr[0])
        || (core_req.size == 2'd2 && core_req.addr[1:0] != 2'd0)) |=> !core_resp.hit)
        else $error("unaligned remap");
    a_bkpt_data: assert property (
        s_bkpt |=> core_rvalid && core_rdata == `FPB_BKPT_INSN) else $error("bad bkpt data");
    a_ram_data: assert property (
        s_hit |=> core_rvalid && core_rdata == $past(ram_rdata)) else $error("bad ram data");
    a_flash_data: assert property (
        s_miss |=> core_rvalid && core_rdata == $past(flash_rdata)) else $error("bad flash data");
    a_ack_time: assert property (
        $rose(wb_req.cyc && wb_req.stb) |-> ##[1:2] wb_ack_o) else $error("late ack");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("long ack");
endmodule
`default_nettype wire

// ### sim/fpb_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpb_params.svh"
// ====
// Bench.
module fpb_unit_test;
    localparam logic [31:0] base_a = 32'h2000_0100;
    logic clk = 0, sys_rst = 1, wb_ack_o, flash_valid, ram_valid, core_rvalid;
    logic [31:0] wb_dat_o, prot_addr, flash_rdata, ram_rdata, core_rdata, r;
    fpb_pkg::fpb_wb_req_t wb_req = '0;
    fpb_pkg::fpb_req_t core_req = '0;
    fpb_pkg::fpb_resp_t core_resp;
    int miscompares = 0, n_compared = 0, cycles = 0;
    logic [34:0] q_resp[$], e;
    logic [31:0] q_data[$], q_wb[$], q_orig[$];
    fpb_unit uut (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .wb_req      (wb_req),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .core_req    (core_req),
        .core_resp   (core_resp),
        .prot_addr   (prot_addr),
        .flash_valid (flash_valid),
        .flash_rdata (flash_rdata),
        .ram_valid   (ram_valid),
        .ram_rdata   (ram_rdata),
        .core_rvalid (core_rvalid),
        .core_rdata  (core_rdata)
    );
    fpb_mem_model mem (
        .clk         (clk),
        .core_resp   (core_resp),
        .prot_addr   (prot_addr),
        .flash_valid (flash_valid),
        .flash_rdata (flash_rdata),
        .ram_valid   (ram_valid),
        .ram_rdata   (ram_rdata)
    );
    initial forever #10 clk = ~clk;
    task check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // A read carries its expected value in the data field.
    task wb(input logic we, input logic [31:0] a, d);
        wb_req <= '{a, d, 4'hF, we, 1'b1, 1'b1};
        if (!we) q_wb.push_back(d);
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        wb_req <= '0;
        @(posedge clk);
    endtask
    // Expected word: care, breakpoint, hit, address.
    task op(input logic lit, input logic [31:0] a, input logic [1:0] sz, input logic [34:0] x);
        core_req <= '{1'b1, lit, a, sz};
        q_resp.push_back(x);
        q_orig.push_back(a);
        q_data.push_back(x[33] ? `FPB_BKPT_INSN : x[32] ? x[31:0] ^ 32'h5A5A_5A5A : ~a);
        @(posedge clk);
        core_req.valid <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (wb_ack_o === 1'b1 && wb_req.we === 1'b0) check("wb", wb_dat_o, q_wb.pop_front());
        if (core_resp.valid === 1'b1) begin
            e = q_resp.pop_front();
            check("prot", prot_addr, q_orig.pop_front());
            check("bkpt", {31'b0, core_resp.bkpt}, {31'b0, e[33]});
            if (e[34]) check("hit", {31'b0, core_resp.hit}, {31'b0, e[32]});
            if (e[34]) check("addr", core_resp.addr, e[31:0]);
        end
        if (core_rvalid === 1'b1) check("data", core_rdata, q_data.pop_front());
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'h4e9e));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        wb(0, 32'h0000_0004, 32'h2000_0000);
        wb(0, 32'h0000_0000, 32'h0000_0000);
        wb(1, 32'h0000_0004, base_a);
        wb(1, 32'h0000_0010, 32'h0000_0101);
        wb(1, 32'h0000_0014, 32'h0000_0203);
        wb(1, 32'h0000_0018, 32'h0000_0400);
        wb(1, 32'h0000_0028, 32'h0000_0301);
        wb(1, 32'h0000_0040, 32'hFFFF_FFFF);
        wb(0, 32'h0000_0040, 32'h0000_0000);
        wb(0, 32'h0000_0004, base_a);
        op(0, 32'h0000_0100, 2, {3'b100, 32'h0000_0100});
        wb(1, 32'h0000_0000, 32'h0000_0001);
        op(0, 32'h0000_0102, 1, {3'b101, base_a + 2});
        op(0, 32'h0000_0200, 2, {3'b010, 32'h0000_0000});
        op(0, 32'h0000_0400, 2, {3'b100, 32'h0000_0400});
        op(1, 32'h0000_0300, 2, {3'b101, base_a + 24});
        op(1, 32'h0000_0302, 1, {3'b101, base_a + 26});
        op(1, 32'h0000_0302, 2, {3'b100, 32'h0000_0302});
        op(1, 32'h0000_0301, 1, {3'b100, 32'h0000_0301});
        for (int i = 0; i < 20; i++) begin
            r = $urandom | 32'h1000_0000;
            op(r[3], r, (r[5:4] == 2'd3) ? 2'd2 : r[5:4], {3'b100, r});
        end
        wb(1, 32'h0000_0000, 32'h0000_0000);
        op(0, 32'h0000_0102, 1, {3'b100, 32'h0000_0102});
        repeat (4) @(posedge clk);
        check("left", q_resp.size() + q_data.size() + q_wb.size() + q_orig.size(), 0);
        final_report();
    end
endmodule
bind fpb_unit fpb_unit_chk chk (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .wb_req      (wb_req),
    .wb_ack_o    (wb_ack_o),
    .core_req    (core_req),
    .core_resp   (core_resp),
    .prot_addr   (prot_addr),
    .flash_valid (flash_valid),
    .flash_rdata (flash_rdata),
    .ram_valid   (ram_valid),
    .ram_rdata   (ram_rdata),
    .core_rvalid (core_rvalid),
    .core_rdata  (core_rdata)
);
`default_nettype wire
